/* File: hdl/remote_serial_command_front_end.v */
// Remote serial command front end with its transmit FIFO.
// Assumes byte receive and transmit logic on ref_clk; no flow control lines.
`timescale 1ns/1ps
`include "serial_front_end_defs.vh"

module tx_byte_fifo
#(
	parameter WIDTH = `TX_FIFO_WIDTH,
	parameter DEPTH = `TX_FIFO_DEPTH,
	parameter AW    = `TX_FIFO_AW
)
(
	// Clock and reset
	input  wire             ref_clk,
	input  wire             reset,
	// Fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// Drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_r;
	reg  [AW-1:0]    rd_ptr_r;
	reg  [AW:0]      count_r;
	wire             push;
	wire             pop;

	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

module remote_serial_command_front_end
#(
	parameter FIFO_DEPTH = `TX_FIFO_DEPTH,
	parameter FIFO_AW    = `TX_FIFO_AW
)
(
	// Clock and reset
	input  wire       ref_clk,
	input  wire       reset,
	// Saved parameters
	input  wire [7:0] remote_enable_parameter,
	input  wire [7:0] unit_address_parameter,
	input  wire       service_request_mode,
	input  wire [7:0] service_request_char,
	// Received bytes from the serial receiver
	input  wire [7:0] rx_data,
	input  wire       rx_valid,
	// Bytes to the serial transmitter
	output wire [7:0] tx_data,
	output wire       tx_valid,
	input  wire       tx_ready,
	// Command bytes to the interpreter
	output reg  [7:0] cmd_data_r,
	output reg        cmd_valid_r,
	output reg        cmd_end_r,
	// Response bytes from the interpreter
	input  wire [7:0] rsp_data,
	input  wire       rsp_valid,
	input  wire       rsp_last,
	output wire       rsp_ready,
	// Events for service requests
	input  wire       event_pulse,
	// Mode and status
	output reg        remote_mode_r,
	output reg        unit_open_r,
	output reg        chain_reset_r,
	output reg        echo_overrun_r
);
	// Open sequence states
	localparam [1:0] SEQ_IDLE   = 2'b00;
	localparam [1:0] SEQ_FIRST  = 2'b01;
	localparam [1:0] SEQ_SECOND = 2'b10;

	reg  [1:0] seq_state_r;
	reg  [1:0] seq_state_nxt;
	reg        init_pending_r;
	reg        srq_pending_r;
	reg        eos_pending_r;
	reg        echo_pending_r;
	reg  [7:0] echo_data_r;
	reg  [7:0] fifo_in_data;
	reg        fifo_in_valid;
	reg        seq_open;
	reg        seq_close;
	reg        seq_bad;
	wire       fifo_in_ready;
	wire [7:0] own_address;
	wire       remote_allowed;
	wire       rx_ctrl;
	wire       push_echo;
	wire       push_srq;
	wire       push_eos;
	wire       push_rsp;

	// True for non-printable codes
	function is_ctrl;
		input [7:0] b;
		begin
			is_ctrl = (b <= `CHAR_CTRL_MAX);
		end
	endfunction

	// Address character in effect
	assign own_address = (unit_address_parameter == `ADDR_UNSET) ?
		`CHAR_DEF_ADDR : unit_address_parameter;

	// Remote needs enable; an unset address falls back to the default A, so it is never unset
	assign remote_allowed = (remote_enable_parameter == `REMOTE_ENABLE_ON) &&
		(own_address != `ADDR_UNSET);

	assign rx_ctrl = is_ctrl(rx_data);

	// Transmit arbitration: echo, then service request, then terminator, then responses
	assign push_echo = echo_pending_r;
	assign push_srq  = !echo_pending_r && srq_pending_r;
	assign push_eos  = !echo_pending_r && !srq_pending_r && eos_pending_r;
	assign push_rsp  = !echo_pending_r && !srq_pending_r && !eos_pending_r &&
		rsp_valid && remote_mode_r && unit_open_r;
	assign rsp_ready = fifo_in_ready && push_rsp;

	always @*
	begin
		fifo_in_data  = rsp_data;
		fifo_in_valid = 1'b0;
		if (push_echo)
		begin
			fifo_in_data  = echo_data_r;
			fifo_in_valid = 1'b1;
		end
		else if (push_srq)
		begin
			fifo_in_data  = service_request_char;
			fifo_in_valid = 1'b1;
		end
		else if (push_eos)
		begin
			fifo_in_data  = `CHAR_EOS;
			fifo_in_valid = 1'b1;
		end
		else if (push_rsp)
		begin
			fifo_in_data  = rsp_data;
			fifo_in_valid = 1'b1;
		end
	end

	// Open sequence decoding
	always @*
	begin
		seq_state_nxt = seq_state_r;
		seq_open      = 1'b0;
		seq_close     = 1'b0;
		seq_bad       = 1'b0;
		if (rx_valid)
		begin
			case (seq_state_r)
				SEQ_IDLE:
				begin
					if (rx_data == `CHAR_OPEN_FIRST)
						seq_state_nxt = SEQ_FIRST;
				end
				SEQ_FIRST:
				begin
					if (rx_data == `CHAR_OPEN_SECOND)
						seq_state_nxt = SEQ_SECOND;
					else
					begin
						seq_bad       = 1'b1;
						seq_state_nxt = SEQ_IDLE;
					end
				end
				SEQ_SECOND:
				begin
					seq_state_nxt = SEQ_IDLE;
					if (rx_ctrl)
						seq_bad = 1'b1;
					else if (rx_data == own_address)
						seq_open = 1'b1;
					else
						seq_close = 1'b1;
				end
				default:
					seq_state_nxt = SEQ_IDLE;
			endcase
		end
	end

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			seq_state_r    <= SEQ_IDLE;
			init_pending_r <= 1'b1;
			remote_mode_r  <= 1'b0;
			unit_open_r    <= 1'b0;
			chain_reset_r  <= 1'b0;
			cmd_data_r     <= 8'h00;
			cmd_valid_r    <= 1'b0;
			cmd_end_r      <= 1'b0;
			srq_pending_r  <= 1'b0;
			eos_pending_r  <= 1'b0;
			echo_pending_r <= 1'b0;
			echo_data_r    <= 8'h00;
			echo_overrun_r <= 1'b0;
		end
		else
		begin
			seq_state_r   <= seq_state_nxt;
			chain_reset_r <= seq_bad;
			cmd_valid_r   <= 1'b0;
			cmd_end_r     <= 1'b0;
			init_pending_r <= 1'b0;

			// Mode after reset follows the saved parameters
			if (init_pending_r)
				remote_mode_r <= remote_allowed;
			else if (rx_valid && rx_data == `CHAR_TOGGLE)
			begin
				// Every unit sees the same byte, so a remote chain goes local
				if (remote_mode_r)
					remote_mode_r <= 1'b0;
				else
					remote_mode_r <= remote_allowed;
			end

			// Unit selection
			if (seq_bad || (rx_valid && rx_data == `CHAR_TOGGLE))
				unit_open_r <= 1'b0;
			else if (seq_open && remote_mode_r)
				unit_open_r <= 1'b1;
			else if (seq_close)
				unit_open_r <= 1'b0;

			// Command bytes go on only to an open remote unit
			if (rx_valid && remote_mode_r && unit_open_r && seq_state_r == SEQ_IDLE)
			begin
				if (rx_data == `CHAR_EOS)
					cmd_end_r <= 1'b1;
				else if (!rx_ctrl)
				begin
					cmd_data_r  <= rx_data;
					cmd_valid_r <= 1'b1;
				end
			end

			// Echo of control bytes; a new one overruns an unsent one
			if (rx_valid && rx_ctrl)
			begin
				echo_data_r    <= rx_data;
				echo_pending_r <= 1'b1;
				if (echo_pending_r && !fifo_in_ready)
					echo_overrun_r <= 1'b1;
			end
			else if (push_echo && fifo_in_ready)
				echo_pending_r <= 1'b0;

			// Service request, set wins over clear
			if (event_pulse && service_request_mode && remote_mode_r)
				srq_pending_r <= 1'b1;
			else if (push_srq && fifo_in_ready)
				srq_pending_r <= 1'b0;

			// Terminator after the last response byte
			if (rsp_ready && rsp_last)
				eos_pending_r <= 1'b1;
			else if (push_eos && fifo_in_ready)
				eos_pending_r <= 1'b0;
		end
	end

	tx_byte_fifo
	#(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	)
	u_tx_fifo
	(
		.ref_clk   (ref_clk),
		.reset     (reset),
		.in_data   (fifo_in_data),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);
endmodule

/* File: hdl/serial_front_end_defs.vh */
// Character codes and sizes for the remote serial command front end.
// Assumes inclusion by the front end file only; definitions only.
`ifndef SERIAL_FRONT_END_DEFS_VH
`define SERIAL_FRONT_END_DEFS_VH

// End of string, line feed
`define CHAR_EOS        8'h0a
// Local and remote toggle
`define CHAR_TOGGLE     8'h01
// First byte of the open sequence
`define CHAR_OPEN_FIRST 8'h03
// Second byte of the open sequence
`define CHAR_OPEN_SECOND 8'h02
// Address used when none is configured, ASCII A
`define CHAR_DEF_ADDR   8'h41
// Highest non-printable code
`define CHAR_CTRL_MAX   8'h1f
// Unit address value meaning not configured
`define ADDR_UNSET      8'h00
// Remote enable parameter value that enables remote operation
`define REMOTE_ENABLE_ON 8'h01
// Default depth and width of the transmit FIFO
`define TX_FIFO_DEPTH   8
`define TX_FIFO_AW      3
`define TX_FIFO_WIDTH   8

`endif

/* File: testbench/host_model.sv */
// Host model: sends bytes, drains the transmit stream
// Assumes the bench calls send and sets stall
`timescale 1ns/1ps
module host_model
(
	// Clock
	input  wire       ref_clk,
	// Link
	output reg  [7:0] rx_data,
	output reg        rx_valid,
	input  wire       tx_valid,
	output reg        tx_ready
);
	reg stall = 1'b0;
	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// Sink with ready on random cycles, held low while stall is set
	always @(posedge ref_clk)
		tx_ready <= !stall && $urandom % 2;
	// One byte, line released with inverse value
	task send(input [7:0] b);
		begin
			@(posedge ref_clk);
			rx_data <= b;
			rx_valid <= 1'b1;
			@(posedge ref_clk);
			rx_data <= ~b;
			rx_valid <= 1'b0;
		end
	endtask
endmodule

/* File: testbench/remote_serial_command_front_end_monitor.sv */
// Checker on the front end ports
// Assumes bind onto the top module
`timescale 1ns/1ps
module front_end_monitor
(
	// Clock and reset
	input wire       ref_clk,
	input wire       reset,
	// Watched ports
	input wire [7:0] unit_address_parameter,
	input wire [7:0] remote_enable_parameter,
	input wire [7:0] rx_data,
	input wire       rx_valid,
	input wire [7:0] tx_data,
	input wire       tx_valid,
	input wire       tx_ready,
	input wire [7:0] cmd_data_r,
	input wire       cmd_valid_r,
	input wire       cmd_end_r,
	input wire       rsp_ready,
	input wire       remote_mode_r,
	input wire       unit_open_r,
	input wire       chain_reset_r
);
	wire [7:0] ad = (unit_address_parameter == 8'h00) ? 8'h41 : unit_address_parameter;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	cmd_fwd_a: assert property (cmd_valid_r |-> cmd_data_r > 8'h1f
		&& $past(rx_valid) && cmd_data_r == $past(rx_data)) else $error("bad cmd");
	cmd_end_a: assert property (cmd_end_r |-> $past(rx_valid && rx_data == 8'h0a))
		else $error("bad end");
	ctl_kept_a: assert property (rx_valid && rx_data <= 8'h1f |=> !cmd_valid_r)
		else $error("ctl fwd");
	toggle_local_a: assert property (rx_valid && rx_data == 8'h01 && remote_mode_r
		|=> !remote_mode_r && !unit_open_r) else $error("bad toggle");
	unit_open_a: assert property ($rose(unit_open_r) |-> remote_mode_r
		&& $past(rx_valid) && $past(rx_data) == ad) else $error("bad open");
	init_mode_a: assert property ($fell(reset) && unit_address_parameter != 8'h00
		|=> remote_mode_r == (remote_enable_parameter == 8'h01)) else $error("bad init");
	rsp_gate_a: assert property (rsp_ready |-> remote_mode_r && unit_open_r)
		else $error("bad rsp");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx drop");
	chain_pulse_a: assert property (chain_reset_r |=> !chain_reset_r)
		else $error("long reset");
	cover property ($rose(unit_open_r));
	cover property (cmd_end_r);
	cover property (chain_reset_r);
endmodule
bind remote_serial_command_front_end front_end_monitor mon (.ref_clk, .reset,
	.unit_address_parameter, .remote_enable_parameter, .rx_data, .rx_valid, .tx_data,
	.tx_valid, .tx_ready, .cmd_data_r, .cmd_valid_r, .cmd_end_r, .rsp_ready,
	.remote_mode_r, .unit_open_r, .chain_reset_r);

/* File: testbench/tb_remote_serial_command_front_end.sv */
// Bench for the remote serial command front end
// Assumes host model and bound checker
`timescale 1ns/1ps
module tb_remote_serial_command_front_end;
	reg        ref_clk = 1'b0;
	reg        reset = 1'b1;
	reg  [7:0] rsp_data = 8'h00;
	reg        rsp_valid = 1'b0;
	reg        rsp_last = 1'b0;
	reg        event_pulse = 1'b0;
	reg  [7:0] remote_enable_parameter = 8'h01;
	reg  [7:0] unit_address_parameter = 8'h42;
	reg        service_request_mode = 1'b1;
	reg  [7:0] service_request_char = 8'h2a;
	wire [7:0] rx_data, tx_data, cmd_data_r;
	wire       rx_valid, tx_valid, tx_ready, rsp_ready, cmd_valid_r, cmd_end_r;
	wire       remote_mode_r, unit_open_r, chain_reset_r, echo_overrun_r;
	integer    err_count = 0;
	integer    checks = 0;
	integer    cyc = 0;
	integer    i;
	reg  [7:0] b;
	reg  [7:0] exp_tx[$];
	reg  [7:0] exp_cmd[$];
	remote_serial_command_front_end uut
	(
		.ref_clk(ref_clk), .reset(reset), .remote_enable_parameter(remote_enable_parameter),
		.unit_address_parameter(unit_address_parameter),
		.service_request_mode(service_request_mode),
		.service_request_char(service_request_char), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.cmd_data_r(cmd_data_r), .cmd_valid_r(cmd_valid_r), .cmd_end_r(cmd_end_r),
		.rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
		.rsp_ready(rsp_ready), .event_pulse(event_pulse), .remote_mode_r(remote_mode_r),
		.unit_open_r(unit_open_r), .chain_reset_r(chain_reset_r),
		.echo_overrun_r(echo_overrun_r)
	);
	host_model h (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_valid(tx_valid), .tx_ready(tx_ready));
	initial
		forever #10 ref_clk = ~ref_clk;
	task chk(input string n, input [7:0] seen, input [7:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp)
			begin
				err_count = err_count + 1;
				$display("BAD %s expected %h seen %h", n, exp, seen);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", checks, err_count);
			if (err_count == 0 && checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task push(input [7:0] d, input l);
		begin
			@(posedge ref_clk);
			rsp_data <= d;
			rsp_valid <= 1'b1;
			rsp_last <= l;
			exp_tx.push_back(d);
			@(posedge ref_clk);
			while (rsp_ready !== 1'b1)
				@(posedge ref_clk);
			rsp_valid <= 1'b0;
		end
	endtask
	task drain;
		while (exp_tx.size() != 0)
			@(posedge ref_clk);
	endtask
	task open_unit(input [7:0] a);
		begin
			exp_tx.push_back(8'h03);
			h.send(8'h03);
			exp_tx.push_back(8'h02);
			h.send(8'h02);
			h.send(a);
		end
	endtask
	// Timeout
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 30000)
		begin
			err_count = err_count + 1;
			tally_and_finish;
		end
	end
	// Result watcher
	always @(posedge ref_clk)
	begin
		if (tx_valid && tx_ready)
			chk("tx", tx_data, exp_tx.size() ? exp_tx.pop_front() : 8'hxx);
		if (cmd_valid_r)
			chk("cmd", cmd_data_r, exp_cmd.size() ? exp_cmd.pop_front() : 8'hxx);
	end
	initial
	begin
		b = $urandom(33391);
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		service_request_char <= 8'($urandom);
		repeat (2) @(posedge ref_clk);
		#1 chk("remote", remote_mode_r, 1'b1);
		open_unit(8'h42);
		#1 chk("open", unit_open_r, 1'b1);
		for (i = 0; i < 5; i = i + 1)
		begin
			b = 8'(8'h20 + $urandom % 95);
			exp_cmd.push_back(b);
			h.send(b);
		end
		exp_tx.push_back(8'h0a);
		h.send(8'h0a);
		#1 chk("end", cmd_end_r, 1'b1);
		drain;
		h.stall = 1'b1;
		repeat (2) @(posedge ref_clk);
		for (i = 0; i < 8; i = i + 1)
			push(8'(8'h41 + i), 1'b0);
		@(posedge ref_clk);
		rsp_data <= 8'h4b;
		rsp_valid <= 1'b1;
		rsp_last <= 1'b1;
		@(posedge ref_clk);
		#1 chk("full", rsp_ready, 1'b0);
		h.send(8'h05);
		h.send(8'h06);
		#1 chk("overrun", echo_overrun_r, 1'b1);
		exp_tx.push_back(8'h06);
		exp_tx.push_back(8'h4b);
		exp_tx.push_back(8'h0a);
		h.stall = 1'b0;
		@(posedge ref_clk);
		while (rsp_ready !== 1'b1)
			@(posedge ref_clk);
		rsp_valid <= 1'b0;
		rsp_last <= 1'b0;
		drain;
		event_pulse <= 1'b1;
		exp_tx.push_back(service_request_char);
		@(posedge ref_clk);
		event_pulse <= 1'b0;
		drain;
		service_request_mode <= 1'b0;
		event_pulse <= 1'b1;
		@(posedge ref_clk);
		event_pulse <= 1'b0;
		repeat (4) @(posedge ref_clk);
		service_request_mode <= 1'b1;
		exp_cmd.push_back(8'h51);
		h.send(8'h51);
		open_unit(8'h43);
		#1 chk("close", unit_open_r, 1'b0);
		h.send(8'h5a);
		exp_tx.push_back(8'h03);
		h.send(8'h03);
		h.send(8'h78);
		#1 chk("chain", chain_reset_r, 1'b1);
		for (i = 0; i < 2; i = i + 1)
		begin
			exp_tx.push_back(8'h01);
			h.send(8'h01);
			#1 chk("mode", remote_mode_r, i[0]);
		end
		drain;
		@(posedge ref_clk);
		reset <= 1'b1;
		unit_address_parameter <= 8'h00;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chk("remote", remote_mode_r, 1'b1);
		chk("overrun", echo_overrun_r, 1'b0);
		open_unit(8'h41);
		#1 chk("open", unit_open_r, 1'b1);
		drain;
		@(posedge ref_clk);
		reset <= 1'b1;
		remote_enable_parameter <= 8'h00;
		unit_address_parameter <= 8'h42;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chk("local", remote_mode_r, 1'b0);
		exp_tx.push_back(8'h01);
		h.send(8'h01);
		#1 chk("stay", remote_mode_r, 1'b0);
		drain;
		tally_and_finish;
	end
endmodule
